// >>> hw/eew_ctrl.sv
// Purpose: nonvolatile byte memory control, registers, interrupt request
// Assumes: cpu port strobes come from logic on ref_clk; sub_tick is a pin
// Notes: control register visible through the two indirect ports and on nv_ctrl_reg
`timescale 1ns/1ps
`include "eew_defs.svh"
module eew_ctrl (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [7:0] cpu_wdata,
  input wire logic cpu_idle,
  input wire logic sub_tick,
  input wire logic global_irq_enable,
  input wire logic nv_irq_enable,
  input wire logic stack_full,
  input wire logic irq_ack,
  output logic [7:0] cpu_rdata,
  output logic [3:0] nv_ctrl_reg,
  output logic nv_irq_request,
  output logic irq_vector,
  output logic op_failed
);
  import eew_pkg::*;
  eew_ctrl_s s; // registered state
  eew_ctrl_s n; // next state
  logic [7:0] mem [0:`EEW_MEM_DEPTH-1]; // stored bytes
  logic mem_we; // store strobe
  logic timer_start; // launch write timer
  logic timer_abort; // cancel write timer
  logic timer_done; // write timer elapsed
  logic hit1; // indirect port 1 points at control
  logic hit2; // indirect port 2 points at control
  logic ctrl_wr; // control register write
  logic write_end; // write finishes this cycle

  // pointer pair selects the control register
  function automatic logic is_ctrl(input logic [7:0] high, input logic [7:0] low);
    is_ctrl = (high == `EEW_CTRL_SECTOR) && (low == `EEW_CTRL_LOC);
  endfunction

  // write cycle timer
  eew_timer u_timer (
    .ref_clk(ref_clk),
    .rst(rst),
    .sub_tick(sub_tick),
    .start(timer_start),
    .abort(timer_abort),
    .done(timer_done)
  );

  // decode of the indirect accesses
  always_comb begin
    hit1 = (cpu_addr == `EEW_SFR_IND1) && is_ctrl(s.p1h, s.p1l);
    hit2 = (cpu_addr == `EEW_SFR_IND2) && is_ctrl(s.p2h, s.p2l);
    ctrl_wr = cpu_wr && (hit1 || hit2);
    write_end = (s.state == EEW_WRITING) && timer_done && !cpu_idle;
  end

  // next state logic
  always_comb begin
    n = s;
    mem_we = 1'b0;
    timer_start = 1'b0;
    timer_abort = 1'b0;
    // direct register writes
    if (cpu_wr) begin
      case (cpu_addr)
        `EEW_SFR_ADDR: n.addr = cpu_wdata[`EEW_ADDR_W-1:0];
        `EEW_SFR_DATA: n.data = cpu_wdata;
        `EEW_SFR_P1L: n.p1l = cpu_wdata;
        `EEW_SFR_P1H: n.p1h = cpu_wdata;
        `EEW_SFR_P2L: n.p2l = cpu_wdata;
        `EEW_SFR_P2H: n.p2h = cpu_wdata;
        default: n.addr = n.addr;
      endcase
    end
    // control register: permits follow the write, starts only set
    if (ctrl_wr) begin
      n.ctrl[`EEW_BIT_WP] = cpu_wdata[`EEW_BIT_WP];
      n.ctrl[`EEW_BIT_RP] = cpu_wdata[`EEW_BIT_RP];
      if (s.state == EEW_IDLE) begin
        if (cpu_wdata[`EEW_BIT_WS] && s.ctrl[`EEW_BIT_WP]) begin
          n.state = EEW_WRITING;
          n.ctrl[`EEW_BIT_WS] = 1'b1;
          n.wr_addr = s.addr;
          n.wr_data = s.data;
          n.failed = 1'b0;
          timer_start = 1'b1;
        end else if (cpu_wdata[`EEW_BIT_RS] && s.ctrl[`EEW_BIT_RP]) begin
          n.state = EEW_READING;
          n.ctrl[`EEW_BIT_RS] = 1'b1;
          n.rd_cnt = `EEW_ZERO4;
          n.failed = 1'b0;
        end
      end
    end
    // operation sequencer
    case (s.state)
      EEW_IDLE: begin
        n.rd_cnt = `EEW_ZERO4;
      end
      EEW_WRITING: begin
        if (cpu_idle) begin
          // low power mode fails the write
          n.state = EEW_IDLE;
          n.ctrl[`EEW_BIT_WS] = 1'b0;
          n.failed = 1'b1;
          timer_abort = 1'b1;
        end else if (timer_done) begin
          mem_we = 1'b1;
          n.state = EEW_IDLE;
          n.ctrl[`EEW_BIT_WS] = 1'b0;
        end
      end
      EEW_READING: begin
        if (cpu_idle) begin
          // low power mode fails the read
          n.state = EEW_IDLE;
          n.ctrl[`EEW_BIT_RS] = 1'b0;
          n.failed = 1'b1;
        end else if (s.rd_cnt == `EEW_READ_LAST) begin
          // fetched byte held in data register
          n.data = mem[s.addr];
          n.state = EEW_IDLE;
          n.ctrl[`EEW_BIT_RS] = 1'b0;
        end else begin
          n.rd_cnt = s.rd_cnt + `EEW_CNT_ONE4;
        end
      end
      default: begin
        n.state = EEW_IDLE;
      end
    endcase
    // interrupt request: servicing clears, write end sets and wins
    if (irq_ack) begin
      n.irq_req = 1'b0;
    end
    if (write_end) begin
      n.irq_req = 1'b1;
    end
    n.irq_vec = s.irq_req && global_irq_enable && nv_irq_enable && !stack_full && !irq_ack;
    // read data port, registered one cycle after the strobe
    if (cpu_rd) begin
      case (cpu_addr)
        `EEW_SFR_ADDR: n.rdata = {1'b0, s.addr};
        `EEW_SFR_DATA: n.rdata = s.data;
        `EEW_SFR_P1L: n.rdata = s.p1l;
        `EEW_SFR_P1H: n.rdata = s.p1h;
        `EEW_SFR_P2L: n.rdata = s.p2l;
        `EEW_SFR_P2H: n.rdata = s.p2h;
        `EEW_SFR_IND1: n.rdata = hit1 ? {`EEW_ZERO4, s.ctrl} : `EEW_ZERO8;
        `EEW_SFR_IND2: n.rdata = hit2 ? {`EEW_ZERO4, s.ctrl} : `EEW_ZERO8;
        default: n.rdata = `EEW_ZERO8;
      endcase
    end
  end

  // state register; reset clears permits and pointer high bytes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // byte array; contents survive reset
  always_ff @(posedge ref_clk) begin
    if (mem_we) begin
      mem[s.wr_addr] <= s.wr_data;
    end
  end

  // outputs straight from flops
  assign cpu_rdata = s.rdata;
  assign nv_ctrl_reg = s.ctrl;
  assign nv_irq_request = s.irq_req;
  assign irq_vector = s.irq_vec;
  assign op_failed = s.failed;

  chk_start_permit: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_wr && cpu_wdata[`EEW_BIT_WS] && !s.ctrl[`EEW_BIT_WP])
    |=> (s.state != EEW_WRITING) || $past(s.state == EEW_WRITING))
    else $error("write started without permit");

  chk_write_capture: assert property (@(posedge ref_clk) disable iff (rst)
    (s.state == EEW_IDLE ##1 s.state == EEW_WRITING)
    |-> (s.wr_addr == $past(s.addr)) && (s.wr_data == $past(s.data)))
    else $error("write address or data not captured");

  chk_write_clear: assert property (@(posedge ref_clk) disable iff (rst)
    write_end |=> !s.ctrl[`EEW_BIT_WS] && (s.state == EEW_IDLE))
    else $error("write start not cleared at end");

  chk_irq_set: assert property (@(posedge ref_clk) disable iff (rst)
    write_end |=> s.irq_req)
    else $error("request not set at write end");

  chk_vector_gate: assert property (@(posedge ref_clk) disable iff (rst)
    s.irq_vec |-> $past(s.irq_req && global_irq_enable && nv_irq_enable && !stack_full))
    else $error("vector without all conditions");

  chk_ack_clear: assert property (@(posedge ref_clk) disable iff (rst)
    (irq_ack && !write_end) |=> !s.irq_req)
    else $error("request not cleared by service");

  chk_idle_abort: assert property (@(posedge ref_clk) disable iff (rst)
    ((s.state != EEW_IDLE) && cpu_idle) |=> (s.state == EEW_IDLE) && s.failed)
    else $error("operation survived low power entry");

  chk_read_timing: assert property (@(posedge ref_clk) disable iff (rst)
    (s.state == EEW_IDLE ##1 (s.state == EEW_READING && !cpu_idle)[*4])
    |=> (s.state == EEW_IDLE) && !s.ctrl[`EEW_BIT_RS])
    else $error("read did not finish in four cycles");

  chk_addr_top: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_rd && cpu_addr == `EEW_SFR_ADDR) |=> !cpu_rdata[7])
    else $error("address top bit not zero");

  chk_sector_gate: assert property (@(posedge ref_clk) disable iff (rst)
    (cpu_rd && cpu_addr == `EEW_SFR_IND1 && s.p1h != `EEW_CTRL_SECTOR) |=> cpu_rdata == `EEW_ZERO8)
    else $error("control visible outside sector one");
endmodule

// >>> hw/eew_defs.svh
// Purpose: constants for the nonvolatile byte memory write/read control
// Assumes: 8-bit special function register port, one 100 MHz clock
// Notes: sector-0 register locations are local choices
// Operation
// - write start ignored unless permit already set
// - write cycle timed by asynchronous sub timer
// - hardware clears write start at cycle end
// - power-on clears write permit bit
// - power-on zeroes both pointer high bytes
// - write end sets memory interrupt request
// - vector needs request, both enables, stack room
// - servicing interrupt clears request automatically
// - idle or sleep during operation fails it
// - control register reached indirectly at sector one
// - 128 bytes, 7-bit address, 8-bit data
// - control bits three to zero, upper read zero
// - read needs permit, clears start, holds byte
`ifndef EEW_DEFS_SVH
`define EEW_DEFS_SVH
`define EEW_ADDR_W 7
`define EEW_MEM_DEPTH 128
`define EEW_ZERO8 8'h00
`define EEW_ZERO4 4'h0
`define EEW_ZERO7 7'h00
`define EEW_ZERO6 6'h00
`define EEW_SFR_IND1 8'h02
`define EEW_SFR_P1L 8'h03
`define EEW_SFR_P1H 8'h04
`define EEW_SFR_P2L 8'h05
`define EEW_SFR_P2H 8'h06
`define EEW_SFR_IND2 8'h07
`define EEW_SFR_ADDR 8'h1E
`define EEW_SFR_DATA 8'h1F
`define EEW_CTRL_LOC 8'h40
`define EEW_CTRL_SECTOR 8'h01
`define EEW_BIT_WP 3
`define EEW_BIT_WS 2
`define EEW_BIT_RP 1
`define EEW_BIT_RS 0
`define EEW_READ_LAST 4'h3
`define EEW_WRITE_LAST 6'h1F
`define EEW_CNT_ONE4 4'h1
`define EEW_CNT_ONE6 6'h01
`endif

// >>> hw/eew_pkg.sv
// Purpose: types shared by the control and its write timer
// Assumes: constants come from eew_defs.svh
// Notes: state of each module is one packed struct, except the control's byte array
package eew_pkg;
  // operation sequencer states
  typedef enum logic [1:0] {
    EEW_IDLE = 2'b00,
    EEW_WRITING = 2'b01,
    EEW_READING = 2'b10
  } eew_state_e;
  // write timer state
  typedef struct packed {
    logic tick_s1;
    logic tick_s2;
    logic tick_d;
    logic busy;
    logic [5:0] cnt;
    logic done;
  } eew_timer_s;
  // control state
  typedef struct packed {
    eew_state_e state;
    logic [6:0] addr;
    logic [7:0] data;
    logic [3:0] ctrl;
    logic [7:0] p1l;
    logic [7:0] p1h;
    logic [7:0] p2l;
    logic [7:0] p2h;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [3:0] rd_cnt;
    logic irq_req;
    logic irq_vec;
    logic failed;
    logic [7:0] rdata;
  } eew_ctrl_s;
endpackage

// >>> hw/eew_timer.sv
// Purpose: write cycle timer running on the slow sub oscillator tick
// Assumes: sub_tick is asynchronous to ref_clk
// Notes: done is a one-cycle pulse; abort drops a running cycle
`timescale 1ns/1ps
`include "eew_defs.svh"
module eew_timer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic sub_tick,
  input wire logic start,
  input wire logic abort,
  output logic done
);
  import eew_pkg::*;
  eew_timer_s s; // registered state
  eew_timer_s n; // next state

  // next state: synchronise tick, count rising edges while busy
  always_comb begin
    n = s;
    n.tick_s1 = sub_tick;
    n.tick_s2 = s.tick_s1;
    n.tick_d = s.tick_s2;
    n.done = 1'b0;
    if (abort) begin
      // cancelled cycle never reports done
      n.busy = 1'b0;
      n.cnt = `EEW_ZERO6;
    end else if (start) begin
      n.busy = 1'b1;
      n.cnt = `EEW_ZERO6;
    end else if (s.busy && s.tick_s2 && !s.tick_d) begin
      if (s.cnt == `EEW_WRITE_LAST) begin
        n.busy = 1'b0;
        n.done = 1'b1;
      end else begin
        n.cnt = s.cnt + `EEW_CNT_ONE6;
      end
    end
  end

  // state register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign done = s.done;
endmodule

// >>> tb/eew_cpu_model.sv
// Purpose: cpu side of the block: register strobes, slow tick, interrupt service
// Assumes: tasks drive just after a rising edge and release one edge later, two edges later for sfr_wr2
// Notes: slow high delays the interrupt service by seven cycles
`timescale 1ns/1ps
module eew_cpu_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic slow,
  input wire logic irq_vector,
  input wire logic [7:0] cpu_rdata,
  output logic [7:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [7:0] cpu_wdata,
  output logic sub_tick,
  output logic irq_ack
);
  logic [3:0] svc_wait; // cycles the vector has waited
  // idle port levels, and a free running slow oscillator of unrelated phase
  initial begin
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    sub_tick = 1'b0;
    forever #20.3 sub_tick = ~sub_tick;
  end
  // service the vector: acknowledge pulse, prompt or delayed
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      svc_wait <= 4'h0;
      irq_ack <= 1'b0;
    end else begin
      svc_wait <= (irq_vector && !irq_ack) ? svc_wait + 4'h1 : 4'h0;
      irq_ack <= irq_vector && !irq_ack && (!slow || svc_wait == 4'h7);
    end
  end
  // one register write
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  task automatic sfr_wr2(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d1;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wdata <= d2;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask
  // one register read, data taken a cycle after the strobe
  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    v = cpu_rdata;
  endtask
endmodule

// >>> tb/tb_eew_ctrl.sv
// Purpose: self-checking bench for the byte memory control
// Assumes: register port driven by the cpu model
// Notes: write cycle lasts about 130 cycles with the model's slow tick
`timescale 1ns/1ps
`include "eew_defs.svh"
module tb_eew_ctrl;
  localparam logic [7:0] ind1 = `EEW_SFR_IND1;
  localparam logic [7:0] ind2 = `EEW_SFR_IND2;
  localparam logic [7:0] p1h = `EEW_SFR_P1H;
  localparam logic [7:0] a_sfr = `EEW_SFR_ADDR;
  localparam logic [7:0] d_sfr = `EEW_SFR_DATA;
  logic ref_clk, rst, cpu_wr, cpu_rd, cpu_idle, sub_tick, irq_ack, slow;
  logic global_irq_enable, nv_irq_enable, stack_full;
  logic nv_irq_request, irq_vector, op_failed;
  logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
  logic [3:0] nv_ctrl_reg;
  int fails;
  int comparisons;
  eew_ctrl eew_ctrl_i (.ref_clk(ref_clk), .rst(rst), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_idle(cpu_idle), .sub_tick(sub_tick),
    .global_irq_enable(global_irq_enable), .nv_irq_enable(nv_irq_enable),
    .stack_full(stack_full), .irq_ack(irq_ack), .cpu_rdata(cpu_rdata),
    .nv_ctrl_reg(nv_ctrl_reg), .nv_irq_request(nv_irq_request), .irq_vector(irq_vector),
    .op_failed(op_failed));
  eew_cpu_model eew_cpu_model_i (.ref_clk(ref_clk), .rst(rst), .slow(slow),
    .irq_vector(irq_vector), .cpu_rdata(cpu_rdata), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
    .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .sub_tick(sub_tick), .irq_ack(irq_ack));
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("BAD time=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    eew_cpu_model_i.sfr_wr(a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    eew_cpu_model_i.sfr_rd(a, v);
    chk(v, e);
  endtask
  // control bits one cycle after the last write
  task automatic see_ctrl(input logic [3:0] e);
    @(posedge ref_clk);
    #1;
    chk({4'h0, nv_ctrl_reg}, {4'h0, e});
  endtask
  // poll a control bit until hardware clears it
  task automatic wait_low(input int b);
    for (int n = 0; n < 400; n++) begin
      @(posedge ref_clk);
      #1;
      if (nv_ctrl_reg[b] === 1'b0) break;
    end
    // a poll that runs out counts as a mismatch
    chk({7'h00, nv_ctrl_reg[b]}, 8'h00);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end
  initial begin
    rst = 1'b1;
    cpu_idle = 1'b0;
    global_irq_enable = 1'b0;
    nv_irq_enable = 1'b0;
    stack_full = 1'b1;
    slow = 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    see_ctrl(4'h0);
    rdc(a_sfr, 8'h00);
    rdc(d_sfr, 8'h00);
    rdc(p1h, 8'h00);
    rdc(`EEW_SFR_P2H, 8'h00);
    $display("test reset values done");
    wr(ind1, 8'h08);
    see_ctrl(4'h0);
    rdc(ind1, 8'h00);
    wr(ind2, 8'h08);
    see_ctrl(4'h0);
    wr(`EEW_SFR_P1L, `EEW_CTRL_LOC);
    wr(p1h, `EEW_CTRL_SECTOR);
    wr(ind1, 8'h04);
    see_ctrl(4'h0);
    $display("test write protection done");
    wr(a_sfr, 8'hFF);
    rdc(a_sfr, 8'h7F);
    wr(d_sfr, 8'hA5);
    nv_irq_enable <= 1'b1;
    eew_cpu_model_i.sfr_wr2(ind1, 8'h08, 8'h0C);
    global_irq_enable <= 1'b1; // unmasked after the start
    wr(d_sfr, 8'h00);
    wr(a_sfr, 8'h00);
    see_ctrl(4'hC);
    wait_low(2);
    chk({4'h0, nv_ctrl_reg}, 8'h08);
    chk({7'h00, nv_irq_request}, 8'h01);
    chk({7'h00, irq_vector}, 8'h00);
    // free the stack on a rising edge, vector follows one edge later
    @(posedge ref_clk);
    stack_full <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk({7'h00, irq_vector}, 8'h01);
    repeat (12) @(posedge ref_clk);
    #1;
    chk({7'h00, nv_irq_request}, 8'h00);
    chk({7'h00, irq_vector}, 8'h00);
    $display("test write and interrupt done");
    wr(a_sfr, 8'h7F); // address given again
    eew_cpu_model_i.sfr_wr2(ind1, 8'h02, 8'h03);
    wait_low(0);
    rdc(d_sfr, 8'hA5);
    rdc(ind1, 8'h02);
    // second pointer pair reaches the same control register
    wr(`EEW_SFR_P2L, `EEW_CTRL_LOC);
    wr(`EEW_SFR_P2H, `EEW_CTRL_SECTOR);
    rdc(ind2, 8'h02);
    $display("test read back done");
    wr(d_sfr, 8'h3C);
    eew_cpu_model_i.sfr_wr2(ind2, 8'h08, 8'h0C);
    cpu_idle <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({7'h00, op_failed}, 8'h01);
    chk({7'h00, nv_ctrl_reg[2]}, 8'h00);
    @(posedge ref_clk);
    cpu_idle <= 1'b0;
    repeat (150) @(posedge ref_clk);
    #1;
    chk({7'h00, nv_irq_request}, 8'h00);
    wr(a_sfr, 8'h7F);
    eew_cpu_model_i.sfr_wr2(ind2, 8'h02, 8'h03);
    wait_low(0);
    rdc(d_sfr, 8'hA5);
    chk({7'h00, op_failed}, 8'h00);
    wr(ind1, 8'h00);
    wr(p1h, 8'h00);
    wr(`EEW_SFR_P2H, 8'h00);
    see_ctrl(4'h0);
    rdc(ind1, 8'h00);
    rdc(ind2, 8'h00);
    $display("test idle abort done");
    tally_and_finish();
  end
endmodule
